// >>> design/front_panel_regs.vh
// Purpose: Constants for the front-panel status and control block
// Assumes: 125 MHz mclk, 32-bit AXI4-Lite register access
// Notes:   Word offsets, field positions, reset values and timing counts
`ifndef FRONT_PANEL_REGS_VH
`define FRONT_PANEL_REGS_VH

// ****************************************
// Register word offsets (address bits 3:2)
// ****************************************
`define OFS_CTRL        2'h0
`define OFS_STATUS      2'h1
`define OFS_TIMECODE    2'h2
`define OFS_MENU        2'h3

// ****************************************
// Control fields and reset values
// ****************************************
`define CTRL_MODE_LSB   0
`define CTRL_LOOP_BIT   2
`define CTRL_RESTART_BIT 3
`define CTRL_RST_VAL    8'h00
`define MENU_EXIT_RST   4'h7

// ****************************************
// Timecode modes and engine states
// ****************************************
`define MODE_PRODUCE    2'h0
`define MODE_PROD_SYNC  2'h1
`define MODE_READ       2'h2
`define ENG_IDLE        2'h0
`define ENG_RUN         2'h1
`define ENG_PAUSED      2'h2

// ****************************************
// Reproducer states
// ****************************************
`define REP_STOPPED     3'h0
`define REP_PLAYING     3'h1
`define REP_PAUSED      3'h2
`define REP_STILLED     3'h3
`define REP_SEARCHED    3'h4
`define REP_FAULT       3'h5
`define REP_INIT        3'h6

// ****************************************
// Timing
// ****************************************
// 5 ms debounce tick and 250 ms flash phase at 125 MHz, sized to their counters
`define DEB_CYCLES      20'h98968
`define BLINK_CYCLES    25'h1DCD650

// ****************************************
// Bus responses
// ****************************************
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// >>> design/front_panel_status_control.v
// Purpose: Front-panel buttons, wheel menu, unit and reproducer indicators
// Assumes: All inputs synchronous to mclk except buttons and wheel, which are
//          synchronised and debounced here
// Notes:   Registers over AXI4-Lite; display content is given as fields
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`default_nettype none
`include "front_panel_regs.vh"

module front_panel_status_control #(
	parameter             NUM_REPRO  = 8,
	parameter [19:0]      DEB_CYCLES = `DEB_CYCLES,
	parameter [24:0]      BLINK_CYCLES = `BLINK_CYCLES
) (
	input  wire                   mclk,
	input  wire                   reset_n,
	input  wire [3:0]             s_axi_awaddr,
	input  wire                   s_axi_awvalid,
	output reg                    s_axi_awready,
	input  wire [31:0]            s_axi_wdata,
	input  wire [3:0]             s_axi_wstrb,
	input  wire                   s_axi_wvalid,
	output reg                    s_axi_wready,
	output reg  [1:0]             s_axi_bresp,
	output reg                    s_axi_bvalid,
	input  wire                   s_axi_bready,
	input  wire [3:0]             s_axi_araddr,
	input  wire                   s_axi_arvalid,
	output reg                    s_axi_arready,
	output reg  [31:0]            s_axi_rdata,
	output reg  [1:0]             s_axi_rresp,
	output reg                    s_axi_rvalid,
	input  wire                   s_axi_rready,
	input  wire                   btn_start,
	input  wire                   btn_pause,
	input  wire                   btn_reset,
	input  wire                   btn_mute,
	input  wire                   wheel_push,
	input  wire                   wheel_cw,
	input  wire                   wheel_ccw,
	input  wire [NUM_REPRO-1:0]   repro_test,
	input  wire                   fault_detect,
	input  wire                   sync_present,
	input  wire                   sync_locked,
	input  wire                   cmd_ready,
	input  wire                   tc_out_active,
	input  wire [1:0]             eng_state,
	input  wire                   loop_end,
	input  wire                   tc_valid,
	input  wire [31:0]            tc_value,
	input  wire [2:0]             frame_rate,
	input  wire [3*NUM_REPRO-1:0] repro_state,
	output reg                    led_fault_r,
	output reg                    led_sync_r,
	output reg                    led_gen_r,
	output reg                    led_ready_r,
	output reg                    led_run_r,
	output reg                    led_pause_r,
	output reg                    led_stop_r,
	output reg                    led_mute_r,
	output reg                    audio_mute_r,
	output reg  [NUM_REPRO-1:0]   rled_red_r,
	output reg  [NUM_REPRO-1:0]   rled_green_r,
	output reg                    tc_start_r,
	output reg                    tc_listen_r,
	output reg                    tc_restart_r,
	output reg                    tc_halt_r,
	output reg                    tc_ignore_r,
	output reg                    tc_pause_r,
	output reg                    repro_stop_all_r,
	output reg  [NUM_REPRO-1:0]   play_first_media_file_r,
	output reg  [NUM_REPRO-1:0]   repro_stop_r,
	output reg  [NUM_REPRO-1:0]   repro_clear_r,
	output reg  [1:0]             disp_mode_r,
	output reg  [1:0]             disp_state_r,
	output reg  [2:0]             disp_rate_r,
	output reg  [31:0]            disp_tc_r,
	output reg                    disp_dash_r,
	output reg                    menu_active_r,
	output reg  [3:0]             menu_sel_r,
	output reg                    menu_pick_r
);

	localparam NB = 7 + NUM_REPRO;

	// ****************************************
	// Helpers
	// ****************************************
	function is_produce;
		input [1:0] mode;
		begin
			is_produce = (mode == `MODE_PRODUCE) || (mode == `MODE_PROD_SYNC);
		end
	endfunction

	// ****************************************
	// Configuration registers
	// ****************************************
	reg  [1:0]  mode_r;
	reg         loop_en_r;
	reg         restart_en_r;
	reg  [3:0]  menu_exit_r;
	reg         pause_pend_r;

	// ****************************************
	// Button synchronise and debounce
	// ****************************************
	// A shared slow sample tick is cheaper than one counter per button;
	// bounce shorter than the tick period cannot produce a second edge.
	wire [NB-1:0] raw = {repro_test, wheel_ccw, wheel_cw, wheel_push,
		btn_mute, btn_reset, btn_pause, btn_start};
	reg  [NB-1:0] sync1_r;
	reg  [NB-1:0] sync2_r;
	reg  [NB-1:0] deb_r;
	reg  [NB-1:0] deb_prev_r;
	reg  [19:0]   deb_cnt_r;
	reg  [24:0]   blink_cnt_r;
	reg           flash_r;
	wire [NB-1:0] press = deb_r & ~deb_prev_r;

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sync1_r <= {NB{1'b0}};
			sync2_r <= {NB{1'b0}};
			deb_r <= {NB{1'b0}};
			deb_prev_r <= {NB{1'b0}};
			deb_cnt_r <= 20'h00000;
			blink_cnt_r <= 25'h0000000;
			flash_r <= 1'b0;
		end else begin
			sync1_r <= raw;
			sync2_r <= sync1_r;
			deb_prev_r <= deb_r;
			if (deb_cnt_r == DEB_CYCLES - 20'h00001) begin
				deb_cnt_r <= 20'h00000;
				deb_r <= sync2_r;
			end else begin
				deb_cnt_r <= deb_cnt_r + 20'h00001;
			end
			if (blink_cnt_r == BLINK_CYCLES - 25'h0000001) begin
				blink_cnt_r <= 25'h0000000;
				flash_r <= ~flash_r;
			end else begin
				blink_cnt_r <= blink_cnt_r + 25'h0000001;
			end
		end
	end

	wire p_start = press[0];
	wire p_pause = press[1];
	wire p_reset = press[2];
	wire p_mute  = press[3];
	wire p_push  = press[4];
	wire p_cw    = press[5];
	wire p_ccw   = press[6];
	wire [NUM_REPRO-1:0] p_test = press[NB-1:7];

	wire producing = (eng_state == `ENG_RUN) && is_produce(mode_r);

	// ****************************************
	// Timecode engine commands and unit indicators
	// ****************************************
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tc_start_r <= 1'b0;
			tc_listen_r <= 1'b0;
			tc_restart_r <= 1'b0;
			tc_halt_r <= 1'b0;
			tc_ignore_r <= 1'b0;
			tc_pause_r <= 1'b0;
			repro_stop_all_r <= 1'b0;
			pause_pend_r <= 1'b0;
			audio_mute_r <= 1'b0;
			led_fault_r <= 1'b0;
			led_sync_r <= 1'b0;
			led_gen_r <= 1'b0;
			led_ready_r <= 1'b0;
			led_run_r <= 1'b0;
			led_pause_r <= 1'b0;
			led_stop_r <= 1'b0;
			led_mute_r <= 1'b0;
		end else begin
			tc_start_r <= p_start && eng_state == `ENG_IDLE && is_produce(mode_r);
			tc_listen_r <= p_start && eng_state == `ENG_IDLE && !is_produce(mode_r);
			tc_restart_r <= p_start && producing && restart_en_r;
			tc_halt_r <= p_reset && is_produce(mode_r);
			tc_ignore_r <= p_reset && !is_produce(mode_r);
			repro_stop_all_r <= p_reset;
			tc_pause_r <= pause_pend_r && producing && loop_end;
			// A new press wins over the clear at the loop point
			if (p_pause && producing && loop_en_r)
				pause_pend_r <= 1'b1;
			else if (loop_end || p_reset || !producing)
				pause_pend_r <= 1'b0;
			if (p_mute)
				audio_mute_r <= ~audio_mute_r;
			led_fault_r <= fault_detect;
			led_sync_r <= sync_present && sync_locked;
			led_gen_r <= producing;
			led_ready_r <= cmd_ready;
			led_run_r <= tc_out_active;
			led_pause_r <= producing && pause_pend_r;
			led_stop_r <= eng_state == `ENG_IDLE;
			// Takes the toggle in the same cycle so it never disagrees with the mute state
			led_mute_r <= audio_mute_r ^ p_mute;
		end
	end

	// ****************************************
	// Reproducer indicators and test buttons
	// ****************************************
	integer i;

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rled_red_r <= {NUM_REPRO{1'b0}};
			rled_green_r <= {NUM_REPRO{1'b0}};
			play_first_media_file_r <= {NUM_REPRO{1'b0}};
			repro_stop_r <= {NUM_REPRO{1'b0}};
			repro_clear_r <= {NUM_REPRO{1'b0}};
		end else begin
			for (i = 0; i < NUM_REPRO; i = i + 1) begin
				play_first_media_file_r[i] <= p_test[i] && repro_state[3*i +: 3] == `REP_STOPPED;
				repro_stop_r[i] <= p_test[i] && repro_state[3*i +: 3] == `REP_PLAYING;
				repro_clear_r[i] <= p_test[i] && repro_state[3*i +: 3] == `REP_FAULT;
				// Orange is red and green together
				case (repro_state[3*i +: 3])
				`REP_INIT: begin
					rled_red_r[i] <= 1'b0;
					rled_green_r[i] <= flash_r;
				end
				`REP_FAULT: begin
					rled_red_r[i] <= flash_r;
					rled_green_r[i] <= 1'b0;
				end
				`REP_STOPPED: begin
					rled_red_r[i] <= 1'b0;
					rled_green_r[i] <= 1'b0;
				end
				default: begin
					if (audio_mute_r) begin
						rled_red_r[i] <= 1'b1;
						rled_green_r[i] <= 1'b0;
					end else begin
						rled_red_r[i] <= repro_state[3*i +: 3] != `REP_PLAYING;
						rled_green_r[i] <= 1'b1;
					end
				end
				endcase
			end
		end
	end

	// ****************************************
	// Status display and wheel menu
	// ****************************************
	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			disp_mode_r <= `MODE_PRODUCE;
			disp_state_r <= `ENG_IDLE;
			disp_rate_r <= 3'h0;
			disp_tc_r <= 32'h00000000;
			disp_dash_r <= 1'b1;
			menu_active_r <= 1'b0;
			menu_sel_r <= 4'h0;
			menu_pick_r <= 1'b0;
		end else begin
			disp_mode_r <= mode_r;
			disp_state_r <= eng_state;
			disp_rate_r <= frame_rate;
			disp_tc_r <= tc_value;
			disp_dash_r <= !tc_valid || eng_state == `ENG_IDLE;
			menu_pick_r <= 1'b0;
			if (!menu_active_r) begin
				if (p_push) begin
					menu_active_r <= 1'b1;
					menu_sel_r <= 4'h0;
				end
			end else if (p_push) begin
				if (menu_sel_r == menu_exit_r)
					menu_active_r <= 1'b0;
				else
					menu_pick_r <= 1'b1;
			end else if (p_cw && !p_ccw) begin
				menu_sel_r <= (menu_sel_r >= menu_exit_r) ? 4'h0 : menu_sel_r + 4'h1;
			end else if (p_ccw && !p_cw) begin
				menu_sel_r <= (menu_sel_r == 4'h0) ? menu_exit_r : menu_sel_r - 4'h1;
			end
		end
	end

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	reg  [1:0]  waddr_r;
	reg  [7:0]  wbyte_r;
	reg         wbyte_en_r;
	reg         aw_got_r;
	reg         w_got_r;
	wire        wr_go = aw_got_r && w_got_r && !s_axi_bvalid;
	wire [1:0]  ra = s_axi_araddr[3:2];
	reg  [31:0] rd_mux;

	always @* begin
		case (ra)
		`OFS_CTRL:     rd_mux = {28'h0000000, restart_en_r, loop_en_r, mode_r};
		`OFS_STATUS:   rd_mux = {18'h00000, menu_sel_r, menu_active_r, pause_pend_r,
			led_fault_r, led_sync_r, led_gen_r, led_ready_r, led_run_r,
			led_pause_r, led_stop_r, led_mute_r};
		`OFS_TIMECODE: rd_mux = disp_tc_r;
		`OFS_MENU:     rd_mux = {28'h0000000, menu_exit_r};
		default:       rd_mux = 32'h00000000;
		endcase
	end

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `RESP_OKAY;
			s_axi_rdata <= 32'h00000000;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			waddr_r <= 2'h0;
			wbyte_r <= 8'h00;
			wbyte_en_r <= 1'b0;
			mode_r <= `MODE_PRODUCE;
			loop_en_r <= 1'b0;
			restart_en_r <= 1'b0;
			menu_exit_r <= `MENU_EXIT_RST;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				aw_got_r <= 1'b1;
				waddr_r <= s_axi_awaddr[3:2];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				w_got_r <= 1'b1;
				wbyte_r <= s_axi_wdata[7:0];
				wbyte_en_r <= s_axi_wstrb[0];
			end
			if (wr_go) begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `RESP_OKAY;
				case (waddr_r)
				`OFS_CTRL: begin
					if (wbyte_en_r) begin
						// Mode 3 is not a legal mode; it falls back to read
						mode_r <= (wbyte_r[1:0] == 2'h3) ? `MODE_READ : wbyte_r[1:0];
						loop_en_r <= wbyte_r[`CTRL_LOOP_BIT];
						restart_en_r <= wbyte_r[`CTRL_RESTART_BIT];
					end
				end
				`OFS_MENU: begin
					if (wbyte_en_r)
						menu_exit_r <= wbyte_r[3:0];
				end
				`OFS_STATUS, `OFS_TIMECODE: s_axi_bresp <= `RESP_SLVERR;
				default: s_axi_bresp <= `RESP_SLVERR;
				endcase
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= `RESP_OKAY;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

// >>> verif/panel_chk.sv
// Purpose: Port-level checks of indicators and action pulses
// Assumes: Single clock, indicators one cycle behind their inputs
// Notes:   Bound into every instance of the block
`default_nettype none
`include "front_panel_regs.vh"
module panel_chk #(parameter int NUM_REPRO = 8) (
	input wire logic mclk, reset_n, fault_detect, sync_present, sync_locked, cmd_ready,
	input wire logic tc_out_active, tc_valid, led_fault_r, led_sync_r, led_ready_r,
	input wire logic led_run_r, led_stop_r, led_pause_r, led_mute_r, audio_mute_r,
	input wire logic disp_dash_r, tc_start_r, tc_listen_r, tc_restart_r, tc_halt_r,
	input wire logic tc_ignore_r, repro_stop_all_r, menu_pick_r, menu_active_r,
	input wire logic [1:0] eng_state, disp_mode_r,
	input wire logic [3*NUM_REPRO-1:0] repro_state,
	input wire logic [NUM_REPRO-1:0] rled_red_r, rled_green_r
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	AST_FAULT: assert property (fault_detect |=> led_fault_r)
		else $error("fault led dark");
	AST_SYNC: assert property (led_sync_r |-> $past(sync_present && sync_locked))
		else $error("sync led without lock");
	AST_READY: assert property (cmd_ready |=> led_ready_r)
		else $error("ready led dark");
	AST_RUN: assert property (tc_out_active |=> led_run_r)
		else $error("run led dark");
	AST_PAUSE: assert property (led_pause_r |-> $past(eng_state) == `ENG_RUN)
		else $error("pause led while not producing");
	AST_STOP: assert property (eng_state == `ENG_IDLE |=> led_stop_r)
		else $error("stop led dark");
	AST_MUTE: assert property (led_mute_r == audio_mute_r)
		else $error("mute led differs from mute state");
	AST_ACT: assert property ((tc_halt_r || tc_ignore_r) == repro_stop_all_r)
		else $error("reset actions split");
	AST_PULSE: assert property ($rose(tc_start_r || tc_listen_r || tc_restart_r)
		|=> !(tc_start_r || tc_listen_r || tc_restart_r)) else $error("start pulse too long");
	AST_MODE: assert property (disp_mode_r != 2'h3)
		else $error("fourth mode shown");
	AST_DASH: assert property (!tc_valid |=> disp_dash_r)
		else $error("no dashes without timecode");
	AST_DARK: assert property ((repro_state[2:0] == `REP_STOPPED) [*2]
		|-> !rled_red_r[0] && !rled_green_r[0]) else $error("stopped reproducer lit");
	AST_PICK: assert property (menu_pick_r |-> menu_active_r)
		else $error("pick outside menu");
endmodule
bind front_panel_status_control panel_chk #(.NUM_REPRO(NUM_REPRO)) chk_u (.*);
`default_nettype wire

// >>> verif/panel_model.sv
// Purpose: Front-panel button model with contact bounce
// Assumes: One-cycle one-hot request per press
// Notes:   A released button reads low through its pull-down
`default_nettype none
module panel_model #(parameter int W = 9, parameter int HOLD = 24) (
	input  wire logic         mclk,
	input  wire logic [W-1:0] req,
	output logic      [W-1:0] btn
);
	timeunit 1ns;
	timeprecision 1ps;
	int           cnt = 0;
	logic [W-1:0] sel = '0;
	always @(posedge mclk) begin
		if (|req) begin
			sel <= req;
			cnt <= HOLD;
		end else if (cnt > 0)
			cnt <= cnt - 1;
	end
	// Bounce is kept shorter than one debounce tick
	assign btn = (cnt == 0 || (cnt > HOLD - 3 && cnt[0])) ? '0 : sel;
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// Purpose: Self-checking bench for the front-panel block
// Assumes: Debounce tick of 4 cycles, blink phase of 8 cycles
// Notes:   Presses come from the panel model and are judged over a fixed window
`default_nettype none
`include "front_panel_regs.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int NR = 2;
	localparam logic [15:0] ROWS [6] = '{16'h808C, 16'h5321, 16'h2B11, 16'h7D72, 16'h010C,
		16'h0205};
	localparam logic [2:0] TST [3] = '{`REP_STOPPED, `REP_PLAYING, `REP_FAULT};
	localparam logic [10:0] TEXP [3] = '{11'h080, 11'h100, 11'h200};
	localparam int MB [7] = '{4, 6, 5, 5, 4, 6, 6};
	localparam logic [4:0] MS [7] = '{5'h10, 5'h17, 5'h10, 5'h11, 5'h11, 5'h10, 5'h17};
	logic mclk = 0, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic btn_start, btn_pause, btn_reset, btn_mute, wheel_push, wheel_cw, wheel_ccw;
	logic fault_detect, sync_present, sync_locked, cmd_ready, tc_out_active, loop_end, tc_valid;
	logic led_fault_r, led_sync_r, led_gen_r, led_ready_r, led_run_r, led_pause_r, led_stop_r;
	logic led_mute_r, audio_mute_r, tc_start_r, tc_listen_r, tc_restart_r, tc_halt_r;
	logic tc_ignore_r, tc_pause_r, repro_stop_all_r, disp_dash_r, menu_active_r, menu_pick_r;
	logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr, menu_sel_r;
	logic [31:0] s_axi_wdata, s_axi_rdata, tc_value, disp_tc_r;
	logic [1:0] s_axi_bresp, s_axi_rresp, eng_state, disp_mode_r, disp_state_r;
	logic [2:0] frame_rate, disp_rate_r;
	logic [NR-1:0] repro_test, rled_red_r, rled_green_r, play_first_media_file_r;
	logic [NR-1:0] repro_stop_r, repro_clear_r;
	logic [3*NR-1:0] repro_state;
	logic [NR+6:0] req = '0, btn;
	logic pr, pg;
	int err_count = 0, comparisons = 0, i, tr, tg;
	wire logic [10:0] pv = {menu_pick_r, repro_clear_r[0], repro_stop_r[0],
		play_first_media_file_r[0], repro_stop_all_r, tc_pause_r, tc_ignore_r, tc_halt_r,
		tc_restart_r, tc_listen_r, tc_start_r};
	front_panel_status_control #(.NUM_REPRO(NR), .DEB_CYCLES(20'h4), .BLINK_CYCLES(25'h8))
		dut_u (.*);
	panel_model #(.W(NR + 7)) pm_u (.mclk, .req, .btn);
	assign {repro_test, wheel_ccw, wheel_cw, wheel_push, btn_mute, btn_reset, btn_pause,
		btn_start} = btn;
	always #4 mclk = ~mclk;
	task automatic check(input string nm, input logic [31:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
			err_count++;
		end
	endtask
	task automatic finish_test();
		$display("comparisons %0d errors %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic axw(input logic [3:0] a, input logic [31:0] d, s, input logic [1:0] er);
		logic ah, wh, bh;
		int t;
		bh = 0;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s[3:0];
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		for (t = 0; t < 50 && !bh; t++) begin
			@(negedge mclk);
			ah = s_axi_awvalid && s_axi_awready;
			wh = s_axi_wvalid && s_axi_wready;
			bh = s_axi_bvalid && s_axi_bready;
			if (bh)
				check("bresp", s_axi_bresp, er);
			@(posedge mclk);
			if (ah)
				s_axi_awvalid <= 0;
			if (wh)
				s_axi_wvalid <= 0;
			if (bh)
				s_axi_bready <= 0;
		end
		if (!bh) begin
			err_count++;
			finish_test();
		end
	endtask
	task automatic axr(input logic [3:0] a, input logic [31:0] exp);
		logic ah, rh;
		int t;
		rh = 0;
		@(posedge mclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		for (t = 0; t < 50 && !rh; t++) begin
			@(negedge mclk);
			ah = s_axi_arvalid && s_axi_arready;
			rh = s_axi_rvalid && s_axi_rready;
			if (rh) begin
				check("rdata", s_axi_rdata, exp);
				check("rresp", s_axi_rresp, `RESP_OKAY);
			end
			@(posedge mclk);
			if (ah)
				s_axi_arvalid <= 0;
			if (rh)
				s_axi_rready <= 0;
		end
		if (!rh) begin
			err_count++;
			finish_test();
		end
	endtask
	// Window covers bounce, debounce ticks, release and every action pulse
	task automatic press(input int b, input logic [10:0] exp);
		logic [10:0] acc;
		int n;
		acc = '0;
		n = 0;
		@(posedge mclk);
		req[b] <= 1'b1;
		@(posedge mclk);
		req <= '0;
		repeat (44) begin
			@(posedge mclk);
			#1;
			acc |= pv;
			n += $countones(pv);
		end
		check("pulses", acc, exp);
		check("pulse count", n, $countones(exp));
	endtask
	initial begin
		reset_n = 0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{fault_detect, sync_present, sync_locked, cmd_ready, tc_out_active, tc_valid} = '0;
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr, eng_state, loop_end} = '0;
		tc_value = 32'h01020304;
		frame_rate = 3'h5;
		repro_state = '0;
		repeat (4) @(posedge mclk);
		#1;
		check("dash in reset", disp_dash_r, 1);
		@(posedge mclk) reset_n <= 1;
		axr(4'hC, 32'h7);
		axw(4'h4, 32'hFF, 4'hF, `RESP_SLVERR);
		axw(4'h0, 32'h8, 4'h0, `RESP_OKAY);
		axr(4'h0, 32'h0);
		for (i = 0; i < 6; i++) begin
			@(posedge mclk) {fault_detect, sync_present, sync_locked, cmd_ready, tc_out_active,
				eng_state, tc_valid} <= ROWS[i][15:8];
			repeat (2) @(posedge mclk);
			#1;
			check("indicators", {led_fault_r, led_sync_r, led_ready_r, led_run_r, led_stop_r,
				disp_dash_r, disp_state_r}, ROWS[i][7:0]);
		end
		@(posedge mclk) tc_valid <= 1;
		repeat (2) @(posedge mclk);
		#1;
		check("timecode", {disp_dash_r, disp_tc_r[30:0]}, 32'h01020304);
		check("rate", disp_rate_r, 3'h5);
		axr(4'h8, 32'h01020304);
		for (i = 0; i < 4; i++) begin
			axw(4'h0, i, 4'hF, `RESP_OKAY);
			repeat (2) @(posedge mclk);
			#1;
			check("mode", disp_mode_r, (i == 3) ? 2 : i);
		end
		@(posedge mclk) eng_state <= `ENG_IDLE;
		press(0, 11'h002);
		press(2, 11'h050);
		axw(4'h0, 32'h0, 4'hF, `RESP_OKAY);
		press(0, 11'h001);
		@(posedge mclk) eng_state <= `ENG_RUN;
		press(0, 11'h000);
		axw(4'h0, 32'h8, 4'hF, `RESP_OKAY);
		press(0, 11'h004);
		check("gen", led_gen_r, 1);
		press(1, 11'h000);
		check("no pause", led_pause_r, 0);
		axw(4'h0, 32'h4, 4'hF, `RESP_OKAY);
		press(1, 11'h000);
		check("pause pending", led_pause_r, 1);
		@(posedge mclk) loop_end <= 1;
		@(posedge mclk) loop_end <= 0;
		#1;
		for (i = 0; i < 4 && tc_pause_r !== 1'b1; i++)
			@(posedge mclk) #1;
		check("pause at loop end", tc_pause_r, 1);
		repeat (2) @(posedge mclk);
		#1;
		check("pause cleared", led_pause_r, 0);
		press(2, 11'h048);
		@(posedge mclk) repro_state <= {`REP_STOPPED, `REP_PLAYING};
		press(3, 11'h000);
		check("muted", {audio_mute_r, led_mute_r, rled_red_r, rled_green_r}, 6'h34);
		press(3, 11'h000);
		check("unmuted", {audio_mute_r, led_mute_r, rled_red_r, rled_green_r}, 6'h01);
		@(posedge mclk) repro_state[2:0] <= `REP_PAUSED;
		repeat (2) @(posedge mclk);
		#1;
		check("orange", {rled_red_r, rled_green_r}, 4'h5);
		for (i = 0; i < 2; i++) begin
			@(posedge mclk) repro_state[2:0] <= i ? `REP_INIT : `REP_FAULT;
			tr = 0;
			tg = 0;
			repeat (24) begin
				@(posedge mclk);
				#1;
				tr += (rled_red_r[0] !== pr);
				tg += (rled_green_r[0] !== pg);
				pr = rled_red_r[0];
				pg = rled_green_r[0];
			end
			check("flash", {tr > 1, tg > 1}, i ? 2'h1 : 2'h2);
		end
		for (i = 0; i < 3; i++) begin
			@(posedge mclk) repro_state[2:0] <= TST[i];
			press(7, TEXP[i]);
		end
		for (i = 0; i < 7; i++) begin
			press(MB[i], (i == 4) ? 11'h400 : 11'h000);
			check("menu", {menu_active_r, menu_sel_r}, MS[i]);
		end
		press(4, 11'h000);
		check("menu exit", menu_active_r, 0);
		press(4, 11'h000);
		press(3, 11'h000);
		check("menu and mute on", {menu_active_r, audio_mute_r}, 2'h3);
		// Mid-run reset must drop the menu, the mute and the written loop enable
		@(posedge mclk) reset_n <= 0;
		repeat (5) @(posedge mclk);
		#1;
		check("reset state", {s_axi_awready, s_axi_arready, s_axi_bvalid, menu_active_r,
			audio_mute_r, led_mute_r, led_pause_r, disp_dash_r}, 8'hC1);
		@(posedge mclk) reset_n <= 1;
		axr(4'h0, 32'h0);
		axr(4'hC, 32'h7);
		finish_test();
	end
endmodule
`default_nettype wire
